/* dv/mcu_parallel_io_ports_bench.sv */
// Self-checking bench for the parallel port block.
// Assumes pin_board resolves every bidirectional pin level.
`timescale 1ns/1ps
module mcu_parallel_io_ports_bench;
  import port_io_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  addr_t      reg_addr = 16'h0000;
  byte_t      reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  byte_t      reg_rdata;
  logic [7:0] port0_in, port0_out, port0_oe, port0_pullup;
  logic [1:0] port1_in, port1_out, port1_oe, port1_pullup;
  logic [7:0] port2_in, port2_out, port2_oe, port2_pullup, port2_irq_req;
  logic [7:0] port3_in, port3_out, port3_oe, port3_pullup;
  logic [7:0] port3_function_select = 8'hFF;
  logic [7:0] sound_outputs = 8'h0A;
  logic [2:0] port6_in = 3'h0;
  logic [7:0] port8_in = 8'h00;
  logic [7:0] segment_outputs = 8'h00;
  logic [7:0] port8_out, port8_oe;
  logic [1:0] display_mode_reg = 2'b00;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] irq_seen = 8'h00;
  logic       irq_clr = 1'b0;
  int         err_count = 0;
  int         n_checks = 0;
  addr_t      rst_addr [7] = '{16'hFF20, 16'hFF21, 16'hFF22, 16'hFF23, 16'hFFF7, 16'hFF32, 16'hFF33};
  byte_t      rst_val [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};

  port_io i_dut (.*);
  pin_board #(.W(8)) i_pin0 (.sys_clk, .dev_out(port0_out), .dev_oe(port0_oe),
    .pull(port0_pullup), .ext_en, .ext_val, .level(port0_in));
  pin_board #(.W(2)) i_pin1 (.sys_clk, .dev_out(port1_out), .dev_oe(port1_oe),
    .pull(port1_pullup), .ext_en(ext_en[1:0]), .ext_val(ext_val[1:0]), .level(port1_in));
  pin_board #(.W(8)) i_pin2 (.sys_clk, .dev_out(port2_out), .dev_oe(port2_oe),
    .pull(port2_pullup), .ext_en, .ext_val, .level(port2_in));
  pin_board #(.W(8)) i_pin3 (.sys_clk, .dev_out(port3_out), .dev_oe(port3_oe),
    .pull(port3_pullup), .ext_en, .ext_val, .level(port3_in));

  // Clock at 20 MHz
  initial forever #25 sys_clk = ~sys_clk;
  // Requests last one cycle, so keep every pulse seen
  always @(posedge sys_clk) irq_seen <= irq_clr ? 8'h00 : (irq_seen | port2_irq_req);

  task automatic check(input byte_t got, input byte_t exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input addr_t a, input byte_t d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input addr_t a, input byte_t exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    check(reg_rdata, exp);
  endtask : rd_chk

  // Pin sync takes four cycles and the output path three
  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask : settle

  task automatic complete_run();
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    foreach (rst_addr[i]) rd_chk(rst_addr[i], rst_val[i]);
    check(port0_oe | port2_oe | port3_oe, 8'h00);
    // Latch written in input mode is kept but not driven
    wr(16'hFF00, 8'hA5);
    settle();
    check(port0_oe, 8'h00);
    wr(16'hFF20, 8'h0F);
    ext_val = 8'h3C;
    ext_en = 8'hFF;
    settle();
    check(port0_oe, 8'hF0);
    check(port0_out & 8'hF0, 8'hA0);
    rd_chk(16'hFF00, 8'hAC);
    wr(16'hFF20, 8'h00);
    settle();
    check(port0_out, 8'hA5);
    ext_en = 8'h00;
    // Low-port pull-ups only on input pins; upper select bits written as zero
    wr(16'hFFF7, 8'h03);
    rd_chk(16'hFFF7, 8'h03);
    wr(16'hFF20, 8'h0F);
    wr(16'hFF21, 8'h01);
    rd_chk(16'hFF21, 8'hFD);
    settle();
    check(port0_pullup, 8'h0F);
    check({6'h00, port1_pullup}, 8'h01);
    check({6'h00, port1_oe}, 8'h02);
    wr(16'hFF01, 8'h03);
    settle();
    check({6'h00, port1_out}, 8'h03);
    rd_chk(16'hFF00, 8'hAF);
    wr(16'hFFF7, 8'h02);
    settle();
    check(port0_pullup, 8'h00);
    // Port 2 pull-ups while driving, and a request per level change
    wr(16'hFF22, 8'h00);
    wr(16'hFF32, 8'h81);
    settle();
    check(port2_pullup, 8'h81);
    check(port2_oe, 8'hFF);
    irq_clr = 1'b1;
    @(negedge sys_clk);
    irq_clr = 1'b0;
    wr(16'hFF02, 8'h01);
    settle();
    check(irq_seen, 8'h01);
    check(port2_out, 8'h01);
    // Port 3 as I/O, then half of it given to sound
    wr(16'hFF23, 8'h00);
    wr(16'hFF03, 8'h3C);
    wr(16'hFF33, 8'h0F);
    settle();
    check(port3_out, 8'h3C);
    wr(16'hFF23, 8'hFF);
    port3_function_select = 8'hF0;
    settle();
    check(port3_oe, 8'h0F);
    check(port3_out & 8'h0F, 8'h0A);
    check(port3_pullup, 8'h0F);
    // Input-only ports and the segment modes
    port6_in = 3'h5;
    port8_in = 8'hC3;
    segment_outputs = 8'h96;
    settle();
    rd_chk(16'hFF06, 8'h05);
    for (int m = 0; m < 3; m++) begin
      display_mode_reg = 2'(m);
      settle();
      check(port8_oe, 8'h00);
      rd_chk(16'hFF08, 8'hC3);
    end
    display_mode_reg = 2'b11;
    settle();
    check(port8_oe, 8'hFF);
    check(port8_out, 8'h96);
    wr(16'hFF10, 8'h55);
    rd_chk(16'hFF10, 8'h00);
    complete_run();
  end
endmodule : mcu_parallel_io_ports_bench

/* dv/pin_board.sv */
// Board-side model of one port's pins.
// Assumes oe high means the device drives the pin.
`timescale 1ns/1ps
module pin_board #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic [W-1:0] dev_out,
  input  wire logic [W-1:0] dev_oe,
  input  wire logic [W-1:0] pull,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] level
);
  logic flip = 1'b0;
  // A loose pin toggles each cycle, so the sync stages never agree and the last settled level is held
  always @(posedge sys_clk) flip <= ~flip;
  // Device wins, then the external source, then the pull-up
  assign level = (dev_oe & dev_out) | (~dev_oe & ext_en & ext_val)
               | (~dev_oe & ~ext_en & (pull | {W{flip}}));
endmodule : pin_board

/* dv/port_io_sva.sv */
// Port-level checker for the parallel port block.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module port_io_sva (
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire port_io_pkg::addr_t reg_addr,
  input wire port_io_pkg::byte_t reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire port_io_pkg::byte_t reg_rdata,
  input wire logic [7:0]         port0_oe,
  input wire logic [7:0]         port0_pullup,
  input wire logic [1:0]         port1_oe,
  input wire logic [1:0]         port1_pullup,
  input wire logic [7:0]         port2_oe,
  input wire logic [7:0]         port2_irq_req,
  input wire logic [7:0]         port3_oe,
  input wire logic [7:0]         port3_function_select,
  input wire logic [1:0]         display_mode_reg,
  input wire logic [7:0]         port8_oe
);
  import port_io_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Write of the port 0 direction byte
  sequence s_dir0_wr;
    reg_wr && reg_addr == 16'hFF20;
  endsequence
  // Segment mode held long enough to reach the pins
  sequence s_seg_held;
    (display_mode_reg == 2'b11) [*2];
  endsequence
  a_dir_drives_oe: assert property (s_dir0_wr |-> ##3 port0_oe == ~$past(reg_wdata, 3))
    else $error("port0 drive enable does not follow direction");
  a_low_pull_input: assert property (((port0_pullup & port0_oe) == 8'h00) && ((port1_pullup & port1_oe) == 2'b00))
    else $error("pull-up on a driven low port pin");
  a_fixed_dir_bits: assert property (reg_rd && reg_addr == 16'hFF21 |=> reg_rdata[7:2] == 6'h3F)
    else $error("port1 direction upper bits not ones");
  a_pull_sel_mask: assert property (reg_rd && reg_addr == 16'hFFF7 |=> reg_rdata[7:2] == 6'h00)
    else $error("pull-up select upper bits not zero");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 16'hFF10 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_seg_drive: assert property (s_seg_held |-> port8_oe == 8'hFF)
    else $error("segment mode not driving port8");
  a_seg_off: assert property ((display_mode_reg != 2'b11) [*2] |-> port8_oe == 8'h00)
    else $error("port8 driven outside segment mode");
  a_no_irq_input: assert property ((port2_oe == 8'h00) [*3] |-> port2_irq_req == 8'h00)
    else $error("port2 request without driven pins");
  a_sound_drive: assert property ($stable(port3_function_select) [*3] |-> (~port3_function_select & ~port3_oe) == 8'h00)
    else $error("sound pin of port3 not driven");
endmodule : port_io_sva

bind port_io port_io_sva i_sva (
  .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .port0_oe, .port0_pullup, .port1_oe, .port1_pullup, .port2_oe, .port2_irq_req,
  .port3_oe, .port3_function_select, .display_mode_reg, .port8_oe
);

/* src/pin_sync.sv */
// Three-stage input synchroniser with agreement filter for pin levels.
// Assumes the pins are asynchronous to sys_clk.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Stage one is read only by stage two, so metastability never reaches logic
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts only once the last two stages agree
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      level <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end
endmodule : pin_sync

/* src/port_bit_cell.sv */
// One bidirectional port bit: output latch drive, pull-up and read mux.
// Assumes the direction bit and synchronised pin level come from the top.
`timescale 1ns/1ps
module port_bit_cell (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic latch_we,
  input  wire logic wdata,
  input  wire logic dir_in,
  input  wire logic pu_sel,
  input  wire logic pu_any_mode,
  input  wire logic pin_level,
  output logic      latch,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pullup_en,
  output logic      rd_bit
);
  // Latch keeps its value until written, even in input mode
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      latch <= 1'b0;
    end else if (latch_we) begin
      latch <= wdata;
    end
  end

  // Registered pin drive: buffer on only while direction is 0
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_out   <= 1'b0;
      pin_oe    <= 1'b0;
      pullup_en <= 1'b0;
    end else begin
      pin_out   <= latch;
      pin_oe    <= ~dir_in;
      pullup_en <= pu_sel & (pu_any_mode | dir_in);
    end
  end

  // Output mode reads the latch, input mode reads the pin
  assign rd_bit = dir_in ? pin_level : latch;
endmodule : port_bit_cell

/* src/port_io.sv */
// Parallel I/O ports 0-3, 6 and 8 with direction and pull-up registers.
// Assumes a simple CPU register strobe bus with byte data and one sys_clk.
// How it works
// - Port 0 has eight pins, latch, and per-bit direction.
// - One select bit enables all port 0 pull-ups on input pins.
// - Port 1 has two pins, latch, direction, one shared pull-up bit.
// - Port 2 has eight pins, per-bit direction, per-pin pull-up in any mode.
// - Port 3 pins act as I/O only where function select allows.
// - Port 3 pull-ups are chosen per pin regardless of direction.
// - Port 6 is three input pins read as pin states.
// - Port 8 is eight inputs, or segment outputs per display mode.
// - Reset sets every direction register to all ones.
// - Output level change on port 2 raises its interrupt request.
// - Sound and segment outputs ignore direction and latch.
// - Ports 0 and 1 pull-ups only on input pins.
// - Low pull-up select resets to zero; bit0 port 0, bit1 port 1.
// - Display mode bits 1 and 0 pick segment drive or input.
// - Read returns pin in input mode, latch in output mode.
// - Write in input mode updates latch but leaves pin undriven.
// - Port 2 and 3 pull-up registers reset to zero.
`timescale 1ns/1ps
`include "port_io_params.svh"
module port_io (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire port_io_pkg::addr_t reg_addr,
  input  wire port_io_pkg::byte_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output port_io_pkg::byte_t      reg_rdata,
  input  wire logic [7:0]         port0_in,
  output logic [7:0]              port0_out,
  output logic [7:0]              port0_oe,
  output logic [7:0]              port0_pullup,
  input  wire logic [1:0]         port1_in,
  output logic [1:0]              port1_out,
  output logic [1:0]              port1_oe,
  output logic [1:0]              port1_pullup,
  input  wire logic [7:0]         port2_in,
  output logic [7:0]              port2_out,
  output logic [7:0]              port2_oe,
  output logic [7:0]              port2_pullup,
  output logic [7:0]              port2_irq_req,
  input  wire logic [7:0]         port3_in,
  output logic [7:0]              port3_out,
  output logic [7:0]              port3_oe,
  output logic [7:0]              port3_pullup,
  input  wire logic [7:0]         port3_function_select,
  input  wire logic [7:0]         sound_outputs,
  input  wire logic [2:0]         port6_in,
  input  wire logic [7:0]         port8_in,
  input  wire logic [1:0]         display_mode_reg,
  input  wire logic [7:0]         segment_outputs,
  output logic [7:0]              port8_out,
  output logic [7:0]              port8_oe
);
  import port_io_pkg::*;

  byte_t       port0_direction;
  byte_t       port1_direction;
  byte_t       port2_direction;
  byte_t       port3_direction;
  byte_t       port2_pullup_bits;
  byte_t       port3_pullup_bits;
  byte_t       low_ports_pullup_select;
  logic [31:0] sync_in;
  logic [31:0] sync_level;
  logic [2:0]  port6_level;
  logic [7:0]  port8_level;
  logic [7:0]  p2_level_q;
  logic [25:0] cell_out;
  logic [25:0] cell_oe;
  logic [25:0] cell_pu;
  logic [25:0] cell_rd;
  logic [25:0] cell_dir;
  logic [25:0] cell_pu_sel;
  logic [25:0] cell_pu_any;
  logic [25:0] cell_we;
  logic [25:0] cell_wdata;
  byte_t       next_rdata;
  logic        seg_mode;
  logic        port0_latch_wr;
  logic        port1_latch_wr;
  logic        port2_latch_wr;
  logic        port3_latch_wr;

  // Decode one register address; shared by the write and read paths
  function automatic logic hit(input addr_t a, input logic [15:0] target);
    hit = (a == target);
  endfunction : hit

  // Segment drive is selected when both display mode bits are set
  assign seg_mode = display_mode_reg[1] & display_mode_reg[0];

  // All outside pins pass the three-stage synchroniser; port 0 bits 7:3 use a
  // second bank so that this one stays a plain 32-bit word
  assign sync_in = {port8_in,        // Bits 31:24
                    port6_in,        // Bits 23:21
                    port3_in,        // Bits 20:13
                    port2_in,        // Bits 12:5
                    port1_in,        // Bits 4:3
                    port0_in[2:0]};  // Bits 2:0

  pin_sync #(.WIDTH(32)) u_sync_a (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  (sync_in),
    .level   (sync_level)
  );

  // Second bank for the upper port 0 pins, same latency as the first
  logic [4:0] sync_b;
  pin_sync #(.WIDTH(5)) u_sync_b (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  (port0_in[7:3]),
    .level   (sync_b)
  );

  assign port8_level = sync_level[31:24];
  assign port6_level = sync_level[23:21];

  // Direction registers: byte writes only, single-bit ops arrive as RMW
  // Port 1 keeps its six unused bits at one so they always read back as inputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port0_direction <= `DIR_RESET;
      port1_direction <= `DIR_RESET;
      port2_direction <= `DIR_RESET;
      port3_direction <= `DIR_RESET;
    end else if (reg_wr) begin
      if (hit(reg_addr, `PORT0_DIR_ADDR)) port0_direction <= reg_wdata;
      if (hit(reg_addr, `PORT1_DIR_ADDR)) port1_direction <= reg_wdata | `PORT1_DIR_FIXED;
      if (hit(reg_addr, `PORT2_DIR_ADDR)) port2_direction <= reg_wdata;
      if (hit(reg_addr, `PORT3_DIR_ADDR)) port3_direction <= reg_wdata;
    end
  end

  // Pull-up select registers; unused upper bits of the low select are forced to zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      low_ports_pullup_select <= `PULLUP_RESET;
      port2_pullup_bits       <= `PULLUP_RESET;
      port3_pullup_bits       <= `PULLUP_RESET;
    end else if (reg_wr) begin
      if (hit(reg_addr, `LOW_PULLUP_ADDR))
        low_ports_pullup_select <= reg_wdata & `LOW_PULLUP_MASK;
      if (hit(reg_addr, `PORT2_PULLUP_ADDR)) port2_pullup_bits <= reg_wdata;
      if (hit(reg_addr, `PORT3_PULLUP_ADDR)) port3_pullup_bits <= reg_wdata;
    end
  end

  // Latch write strobes, one per bidirectional port
  assign port0_latch_wr = reg_wr & hit(reg_addr, `PORT0_DATA_ADDR);
  assign port1_latch_wr = reg_wr & hit(reg_addr, `PORT1_DATA_ADDR);
  assign port2_latch_wr = reg_wr & hit(reg_addr, `PORT2_DATA_ADDR);
  assign port3_latch_wr = reg_wr & hit(reg_addr, `PORT3_DATA_ADDR);

  // Per-cell controls: bits 0-7 port 0, 8-9 port 1, 10-17 port 2, 18-25 port 3
  always_comb begin
    cell_dir    = {port3_direction, port2_direction, port1_direction[1:0], port0_direction};
    cell_pu_sel = {port3_pullup_bits, port2_pullup_bits,
                   {2{low_ports_pullup_select[`LOW_PULLUP_P1_BIT]}},
                   {8{low_ports_pullup_select[`LOW_PULLUP_P0_BIT]}}};
    cell_pu_any = {16'hFFFF, 10'h000};
    cell_wdata  = {reg_wdata, reg_wdata, reg_wdata[1:0], reg_wdata};
    cell_we     = {{8{port3_latch_wr}},
                   {8{port2_latch_wr}},
                   {2{port1_latch_wr}},
                   {8{port0_latch_wr}}};
  end

  logic [25:0] cell_level;
  // Cell order matches the control vectors: port 3, port 2, port 1, then port 0
  assign cell_level = {sync_level[20:13],  // Port 3
                       sync_level[12:5],   // Port 2
                       sync_level[4:3],    // Port 1
                       sync_b,             // Port 0 bits 7:3
                       sync_level[2:0]};   // Port 0 bits 2:0

  // One cell per bidirectional pin: 8 + 2 + 8 + 8 cells
  genvar g;
  generate
    for (g = 0; g < 26; g++) begin : g_cell
      port_bit_cell u_cell (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .latch_we    (cell_we[g]),
        .wdata       (cell_wdata[g]),
        .dir_in      (cell_dir[g]),
        .pu_sel      (cell_pu_sel[g]),
        .pu_any_mode (cell_pu_any[g]),
        .pin_level   (cell_level[g]),
        .latch       (),
        .pin_out     (cell_out[g]),
        .pin_oe      (cell_oe[g]),
        .pullup_en   (cell_pu[g]),
        .rd_bit      (cell_rd[g])
      );
    end
  endgenerate

  // Pin outputs; port 3 bits handed to the sound generator bypass the latch
  // Drive and pull-up both come from cell registers, so they switch on one edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port0_out <= '0;
      port0_oe  <= '0;
      port1_out <= '0;
      port1_oe  <= '0;
      port2_out <= '0;
      port2_oe  <= '0;
      port3_out <= '0;
      port3_oe  <= '0;
    end else begin
      port0_out <= cell_out[7:0];
      port0_oe  <= cell_oe[7:0];
      port1_out <= cell_out[9:8];
      port1_oe  <= cell_oe[9:8];
      port2_out <= cell_out[17:10];
      port2_oe  <= cell_oe[17:10];
      for (int i = 0; i < 8; i++) begin
        if (port3_function_select[i]) begin
          port3_out[i] <= cell_out[18+i];
          port3_oe[i]  <= cell_oe[18+i];
        end else begin
          port3_out[i] <= sound_outputs[i];
          port3_oe[i]  <= 1'b1;
        end
      end
    end
  end

  // Pull-up enables straight from the cells' registered outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port0_pullup <= '0;
      port1_pullup <= '0;
      port2_pullup <= '0;
      port3_pullup <= '0;
    end else begin
      port0_pullup <= cell_pu[7:0];
      port1_pullup <= cell_pu[9:8];
      port2_pullup <= cell_pu[17:10];
      port3_pullup <= cell_pu[25:18];
    end
  end

  // Port 8 segment drive ignores latch and direction entirely
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port8_out <= '0;
      port8_oe  <= '0;
    end else begin
      port8_out <= seg_mode ? segment_outputs : 8'h00;
      port8_oe  <= {8{seg_mode}};
    end
  end

  // Port 2 driven-level edges raise a one-cycle interrupt request per pin
  // Only driven pins count; a latch toggle behind an input pin stays silent
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      p2_level_q    <= '0;
      port2_irq_req <= '0;
    end else begin
      p2_level_q    <= port2_out;
      port2_irq_req <= port2_oe & (port2_out ^ p2_level_q);
    end
  end

  // Read mux; reading never touches a latch
  // A bit operation reads the whole port, so input-mode bits copy their pin state
  // into the latch; software must set latches again before switching to output
  // Port 8 reads zero in segment mode, since its pins are then outputs
  always_comb begin
    next_rdata = 8'h00;
    case (1'b1)
      hit(reg_addr, `PORT0_DATA_ADDR):   next_rdata = cell_rd[7:0];
      hit(reg_addr, `PORT1_DATA_ADDR):   next_rdata = {6'h00, cell_rd[9:8]};
      hit(reg_addr, `PORT2_DATA_ADDR):   next_rdata = cell_rd[17:10];
      hit(reg_addr, `PORT3_DATA_ADDR):   next_rdata = cell_rd[25:18];
      hit(reg_addr, `PORT6_DATA_ADDR):   next_rdata = {5'h00, port6_level};
      hit(reg_addr, `PORT8_DATA_ADDR):   next_rdata = seg_mode ? 8'h00 : port8_level;
      hit(reg_addr, `PORT0_DIR_ADDR):    next_rdata = port0_direction;
      hit(reg_addr, `PORT1_DIR_ADDR):    next_rdata = port1_direction;
      hit(reg_addr, `PORT2_DIR_ADDR):    next_rdata = port2_direction;
      hit(reg_addr, `PORT3_DIR_ADDR):    next_rdata = port3_direction;
      hit(reg_addr, `PORT2_PULLUP_ADDR): next_rdata = port2_pullup_bits;
      hit(reg_addr, `PORT3_PULLUP_ADDR): next_rdata = port3_pullup_bits;
      hit(reg_addr, `LOW_PULLUP_ADDR):   next_rdata = low_ports_pullup_select;
      default:                           next_rdata = 8'h00;
    endcase
  end

  // Read data is registered, valid one cycle after the read strobe
  // It holds between reads, so the CPU may take it any time before the next read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end
endmodule : port_io

/* src/port_io_params.svh */
// Offsets, reset values and field positions of the parallel port block.
// Assumes it is included by its bare name from the design files.
`ifndef PORT_IO_PARAMS_SVH
`define PORT_IO_PARAMS_SVH
`define PORT0_DATA_ADDR       16'hFF00
`define PORT1_DATA_ADDR       16'hFF01
`define PORT2_DATA_ADDR       16'hFF02
`define PORT3_DATA_ADDR       16'hFF03
`define PORT6_DATA_ADDR       16'hFF06
`define PORT8_DATA_ADDR       16'hFF08
`define PORT0_DIR_ADDR        16'hFF20
`define PORT1_DIR_ADDR        16'hFF21
`define PORT2_DIR_ADDR        16'hFF22
`define PORT3_DIR_ADDR        16'hFF23
`define PORT2_PULLUP_ADDR     16'hFF32
`define PORT3_PULLUP_ADDR     16'hFF33
`define LOW_PULLUP_ADDR       16'hFFF7
`define DIR_RESET             8'hFF
`define PULLUP_RESET          8'h00
`define LATCH_RESET           8'h00
`define PORT1_DIR_FIXED       8'hFC
`define LOW_PULLUP_MASK       8'h03
`define LOW_PULLUP_P0_BIT     0
`define LOW_PULLUP_P1_BIT     1
`endif

/* src/port_io_pkg.sv */
// Types shared by the parallel port block.
// Assumes the constants header supplies the numeric values.
package port_io_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] addr_t;
  typedef enum logic [1:0] {
    SEL_PORT0,
    SEL_PORT1,
    SEL_PORT2,
    SEL_PORT3
  } bidir_port_e;
endpackage : port_io_pkg
